//--- rtl/bbf_boost_ctrl.sv
// backlight boost enable decoding and fault supervision with avalon-mm registers
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
// Operation
// - main string enable switches strings one to three together.
// - fourth-string enable is ignored while scene enable is clear.
// - fourth string may turn rail on only with scene enable set.
// - rail on when scene enable set or main enable set without PWM mode, otherwise off, PWM included.
// - fourth string role: camera, zone A, or zone B by enables and dual-zone.
// - dual-zone puts strings one-two in zone A, three in zone B.
// - sink PWM mode drives strings one-three as PWM without the rail.
// - rail turn-on raises fault and UV comparator until steady state is seen with soft-start complete.
// - UV comparator stays on for scene-only, off after ready with main.
// - active UV comparator below threshold raises fault until recovery.
// - over-voltage stops regulator and raises fault until it clears.
// - over-voltage also disables every sink fed from the rail.
// - over-current ends switch cycle, raises fault, limits cycle by cycle.
// - short circuit sensed only from soft-start end to the end of ramp and in the first run cycle, latches rail off and fault until re-enable.
// - short-circuit detection masked during 4.0 ms soft-start.
// - open main string leaves regulation, others keep running.
module bbf_boost_ctrl #(
    parameter int SOFT_START_CYCLES = bbf_pkg::SOFT_START_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // analogue comparators, asynchronous
    input wire logic uv_below_pin,
    input wire logic ov_trip_pin,
    input wire logic oc_trip_pin,
    input wire logic fb_short_pin,
    input wire logic [2:0] main_sink_open_pin,
    input wire logic boost_output_steady_pin,
    // boost stage and sinks
    output logic boost_rail_enable,
    output logic regulator_run,
    output logic switch_gate_allow,
    output logic uv_comparator_enable,
    output logic boost_fault_flag,
    output logic [2:0] main_sink_enable,
    output logic [2:0] main_sink_pwm_mode,
    output logic [2:0] main_sink_zone_b,
    output logic [2:0] main_sink_in_loop,
    output logic fourth_sink_enable,
    output logic [1:0] fourth_string_role,
    output logic fourth_in_loop,
    // interrupt
    output logic irq
);
    localparam int SS_W = $clog2(SOFT_START_CYCLES + 1);

    // three-stage synchroniser, change accepted when stages two and three agree
    logic [7:0] sync1_ff, sync2_ff, sync3_ff;
    logic [7:0] filt_ff;
    // low seven bits follow the sense struct layout
    wire logic [7:0] raw_in = {boost_output_steady_pin, uv_below_pin, ov_trip_pin,
        oc_trip_pin, fb_short_pin, main_sink_open_pin};
    wire logic [7:0] nxt_filt = (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff | sync3_ff));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            sync3_ff <= 8'h00;
            filt_ff <= 8'h00;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            filt_ff <= nxt_filt;
        end
    end

    bbf_pkg::bbf_sense_t sense;
    wire logic steady = filt_ff[7];
    assign sense = bbf_pkg::bbf_sense_t'(filt_ff[6:0]);

    // registers
    bbf_pkg::bbf_ctrl_t ctrl_ff;
    logic [bbf_pkg::EV_W-1:0] irq_stat_ff, irq_mask_ff;
    logic ack_ff;

    function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [7:0] wd,
        input logic en);
        lane_merge = en ? wd : old;
    endfunction : lane_merge

    // one wait state: request acknowledged the cycle after it appears
    wire logic req = (avs_read | avs_write) & ~ack_ff;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    wire logic wr_take = avs_write & ack_ff;
    wire logic rd_take = avs_read & ~ack_ff;
    wire logic sel_ctrl = avs_address == bbf_pkg::OFF_CTRL;
    wire logic sel_stat = avs_address == bbf_pkg::OFF_STATUS;
    wire logic sel_istat = avs_address == bbf_pkg::OFF_IRQ_STAT;
    wire logic sel_imask = avs_address == bbf_pkg::OFF_IRQ_MASK;
    wire logic [4:0] ctrl_wr = 5'(lane_merge({3'h0, ctrl_ff}, avs_writedata[7:0],
        avs_byteenable[0]));
    wire logic [5:0] wr_ones = avs_byteenable[0] ? avs_writedata[5:0] : 6'h00;

    // decoding
    wire logic main_en = ctrl_ff.main_string_enable;
    wire logic scene_en = ctrl_ff.scene_string_enable;
    wire logic dual = ctrl_ff.dual_zone_select;
    wire logic pwm = ctrl_ff.sink_pwm_mode_enable;
    wire logic invalid = pwm & main_en;
    wire logic fourth_bl = scene_en & ctrl_ff.fourth_string_backlight_enable;
    wire logic rail_req = scene_en | (main_en & ~invalid);
    wire logic main_on = (main_en | pwm) & ~invalid;

    // rail state machine
    bbf_pkg::bbf_state_t state_ff, nxt_state;
    logic [SS_W-1:0] ss_cnt_ff;
    logic rail_req_ff;
    wire logic ss_done = ss_cnt_ff == SS_W'(SOFT_START_CYCLES);
    wire logic sc_hit = sense.sc & ss_done;
    wire logic new_enable = rail_req & ~rail_req_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            bbf_pkg::ST_OFF: begin
                if (rail_req) nxt_state = bbf_pkg::ST_RAMP;
            end
            bbf_pkg::ST_RAMP: begin
                if (!rail_req) nxt_state = bbf_pkg::ST_OFF;
                else if (sc_hit) nxt_state = bbf_pkg::ST_SHORT;
                else if (steady && ss_done) nxt_state = bbf_pkg::ST_RUN;
            end
            bbf_pkg::ST_RUN: begin
                if (!rail_req) nxt_state = bbf_pkg::ST_OFF;
                else if (sc_hit) nxt_state = bbf_pkg::ST_SHORT;
            end
            bbf_pkg::ST_SHORT: begin
                if (new_enable) nxt_state = bbf_pkg::ST_RAMP;
                else if (!rail_req) nxt_state = bbf_pkg::ST_SHORT;
            end
            default: nxt_state = bbf_pkg::ST_OFF;
        endcase
    end

    // short latch clears only on re-enable (request falls then rises)
    wire logic rail_on = (state_ff == bbf_pkg::ST_RAMP) | (state_ff == bbf_pkg::ST_RUN);
    wire logic ramping = state_ff == bbf_pkg::ST_RAMP;
    wire logic uv_cmp_on = ramping | ((state_ff == bbf_pkg::ST_RUN) & scene_en & ~main_on
        & ~pwm);
    wire logic uv_fault = uv_cmp_on & (sense.uv | ramping);
    wire logic ov_fault = rail_on & sense.ov;
    wire logic oc_fault = rail_on & sense.oc;
    wire logic sc_fault = state_ff == bbf_pkg::ST_SHORT;
    wire logic any_fault = uv_fault | ov_fault | oc_fault | sc_fault;
    wire logic ready_evt = ramping & (nxt_state == bbf_pkg::ST_RUN);
    wire logic [5:0] events = {ready_evt, |sense.open_str, sc_hit, oc_fault, ov_fault,
        uv_fault & uv_cmp_on & ~ramping};
    wire logic [SS_W-1:0] nxt_ss = !ramping ? '0 : ss_done ? ss_cnt_ff : ss_cnt_ff + 1'b1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= bbf_pkg::ST_OFF;
            ss_cnt_ff <= '0;
            rail_req_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ss_cnt_ff <= nxt_ss;
            rail_req_ff <= rail_req;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= bbf_pkg::bbf_ctrl_t'(bbf_pkg::CTRL_RESET);
            irq_mask_ff <= bbf_pkg::IRQ_MASK_RESET;
            irq_stat_ff <= 6'h00;
            ack_ff <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_ff <= req;
            if (wr_take && sel_ctrl) ctrl_ff <= bbf_pkg::bbf_ctrl_t'(ctrl_wr);
            if (wr_take && sel_imask) irq_mask_ff <= wr_ones;
            // set wins over write-one-to-clear
            irq_stat_ff <= (irq_stat_ff & ~((wr_take & sel_istat) ? wr_ones : 6'h00)) | events;
            if (rd_take) begin
                avs_readdata <= 32'h0000_0000;
                if (sel_ctrl) avs_readdata <= {27'h0, ctrl_ff};
                if (sel_stat) avs_readdata <= {21'h0, state_ff, sense.open_str, any_fault,
                    uv_cmp_on, rail_on, steady};
                if (sel_istat) avs_readdata <= {26'h0, irq_stat_ff};
                if (sel_imask) avs_readdata <= {26'h0, irq_mask_ff};
            end
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // outputs to boost stage and sinks
    logic [2:0] msink_ff, mzone_ff, mloop_ff, mpwm_ff;
    logic rail_ff, reg_ff, gate_ff, uvc_ff, flt_ff, f_en_ff, f_loop_ff;
    logic [1:0] role_ff;
    wire logic [1:0] role = !scene_en ? bbf_pkg::ROLE_OFF :
        dual ? bbf_pkg::ROLE_ZONE_B :
        fourth_bl ? bbf_pkg::ROLE_ZONE_A : bbf_pkg::ROLE_CAMERA;
    wire logic sinks_ok = ~ov_fault & ~sc_fault;
    wire logic [2:0] nxt_msink = {3{main_on & sinks_ok}} & ~sense.open_str;
    wire logic [2:0] nxt_mzone = dual ? 3'h4 : 3'h0;
    wire logic [2:0] nxt_mloop = {3{main_on & ~pwm}} & ~sense.open_str;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msink_ff <= 3'h0;
            mzone_ff <= 3'h0;
            mloop_ff <= 3'h0;
            mpwm_ff <= 3'h0;
            rail_ff <= 1'b0;
            reg_ff <= 1'b0;
            gate_ff <= 1'b0;
            uvc_ff <= 1'b0;
            flt_ff <= 1'b0;
            f_en_ff <= 1'b0;
            f_loop_ff <= 1'b0;
            role_ff <= bbf_pkg::ROLE_OFF;
        end else begin
            msink_ff <= nxt_msink;
            mzone_ff <= nxt_mzone;
            mloop_ff <= nxt_mloop;
            mpwm_ff <= {3{main_on & pwm}};
            rail_ff <= rail_on;
            reg_ff <= rail_on & ~ov_fault;
            gate_ff <= rail_on & ~ov_fault & ~oc_fault;
            uvc_ff <= uv_cmp_on;
            flt_ff <= any_fault;
            f_en_ff <= scene_en & sinks_ok;
            f_loop_ff <= fourth_bl;
            role_ff <= role;
        end
    end

    assign boost_rail_enable = rail_ff;
    assign regulator_run = reg_ff;
    assign switch_gate_allow = gate_ff;
    assign uv_comparator_enable = uvc_ff;
    assign boost_fault_flag = flt_ff;
    assign main_sink_enable = msink_ff;
    assign main_sink_pwm_mode = mpwm_ff;
    assign main_sink_zone_b = mzone_ff;
    assign main_sink_in_loop = mloop_ff;
    assign fourth_sink_enable = f_en_ff;
    assign fourth_string_role = role_ff;
    assign fourth_in_loop = f_loop_ff;

    // checks
    property p_rail_dec;
        @(posedge clk) disable iff (rst) 1'b1 |=> boost_rail_enable == $past(rail_on);
    endproperty
    a_rail_dec: assert property (p_rail_dec) else $error("rail mismatch");
    property p_no_scene;
        @(posedge clk) disable iff (rst) !scene_en |=> fourth_string_role == bbf_pkg::ROLE_OFF
            && !fourth_in_loop;
    endproperty
    a_no_scene: assert property (p_no_scene) else $error("fourth acted w/o scene");
    property p_invalid;
        @(posedge clk) disable iff (rst) invalid |=> main_sink_enable == 3'h0;
    endproperty
    a_invalid: assert property (p_invalid) else $error("strings on when invalid");
    property p_ov;
        @(posedge clk) disable iff (rst) ov_fault |=> !regulator_run && boost_fault_flag
            && main_sink_enable == 3'h0 && !fourth_sink_enable;
    endproperty
    a_ov: assert property (p_ov) else $error("ov not handled");
    property p_oc;
        @(posedge clk) disable iff (rst) oc_fault |=> !switch_gate_allow && boost_fault_flag;
    endproperty
    a_oc: assert property (p_oc) else $error("oc not handled");
    sequence s_short_hit;
        sc_hit ##1 1'b1;
    endsequence
    property p_sc;
        @(posedge clk) disable iff (rst) s_short_hit |=> !boost_rail_enable && boost_fault_flag;
    endproperty
    a_sc: assert property (p_sc) else $error("short not latched");
    property p_ss_mask;
        @(posedge clk) disable iff (rst) ramping && !ss_done |=> state_ff != bbf_pkg::ST_SHORT;
    endproperty
    a_ss_mask: assert property (p_ss_mask) else $error("short during soft-start");
    property p_ramp_flag;
        @(posedge clk) disable iff (rst) ramping |=> boost_fault_flag && uv_comparator_enable;
    endproperty
    a_ramp_flag: assert property (p_ramp_flag) else $error("ramp flag missing");
    property p_open;
        @(posedge clk) disable iff (rst) |sense.open_str |=>
            (main_sink_in_loop & $past(sense.open_str)) == 3'h0;
    endproperty
    a_open: assert property (p_open) else $error("open string kept");
    property p_uv_main;
        @(posedge clk) disable iff (rst) state_ff == bbf_pkg::ST_RUN && main_on |=>
            !uv_comparator_enable;
    endproperty
    a_uv_main: assert property (p_uv_main) else $error("uv comparator on with main");

    // rail follows the request two edges late
    sequence s_rail_idle;
        !rail_req ##1 !rail_req;
    endsequence
    sequence s_rail_start;
        rail_req && state_ff == bbf_pkg::ST_OFF ##1 ramping;
    endsequence
    property p_rail_off;
        @(posedge clk) disable iff (rst) s_rail_idle |=> !boost_rail_enable;
    endproperty
    a_rail_off: assert property (p_rail_off) else $error("rail on without request");
    property p_rail_start;
        @(posedge clk) disable iff (rst) s_rail_start |=> boost_rail_enable;
    endproperty
    a_rail_start: assert property (p_rail_start) else $error("rail not started");

    // string decoding
    property p_main_all;
        @(posedge clk) disable iff (rst) main_on && sinks_ok && sense.open_str == 3'h0
            |=> main_sink_enable == 3'h7;
    endproperty
    a_main_all: assert property (p_main_all) else $error("main strings split");
    property p_zone_split;
        @(posedge clk) disable iff (rst) 1'b1 |=> main_sink_zone_b == ($past(dual) ? 3'h4 : 3'h0);
    endproperty
    a_zone_split: assert property (p_zone_split) else $error("zone split wrong");
    property p_role_camera;
        @(posedge clk) disable iff (rst) scene_en && !dual && !fourth_bl
            |=> fourth_string_role == bbf_pkg::ROLE_CAMERA;
    endproperty
    a_role_camera: assert property (p_role_camera) else $error("camera role wrong");
    property p_role_a;
        @(posedge clk) disable iff (rst) scene_en && !dual && fourth_bl
            |=> fourth_string_role == bbf_pkg::ROLE_ZONE_A;
    endproperty
    a_role_a: assert property (p_role_a) else $error("zone a role wrong");
    property p_role_b;
        @(posedge clk) disable iff (rst) scene_en && dual |=> fourth_string_role == bbf_pkg::ROLE_ZONE_B;
    endproperty
    a_role_b: assert property (p_role_b) else $error("zone b role wrong");
    property p_pwm_sinks;
        @(posedge clk) disable iff (rst) pwm && !main_en
            |=> main_sink_pwm_mode == 3'h7 && main_sink_in_loop == 3'h0;
    endproperty
    a_pwm_sinks: assert property (p_pwm_sinks) else $error("pwm sinks wrong");
    property p_fourth_loop;
        @(posedge clk) disable iff (rst) fourth_bl |=> fourth_in_loop;
    endproperty
    a_fourth_loop: assert property (p_fourth_loop) else $error("fourth not in loop");

    // fault flag and latches
    property p_flag_or;
        @(posedge clk) disable iff (rst) 1'b1 |=> boost_fault_flag == $past(any_fault);
    endproperty
    a_flag_or: assert property (p_flag_or) else $error("flag not or of faults");
    property p_flag_clear;
        @(posedge clk) disable iff (rst) !uv_fault && !ov_fault && !oc_fault && !sc_fault
            |=> !boost_fault_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag stuck");
    property p_sc_hold;
        @(posedge clk) disable iff (rst) sc_fault && !new_enable |=> sc_fault;
    endproperty
    a_sc_hold: assert property (p_sc_hold) else $error("short released early");
    property p_uv_scene;
        @(posedge clk) disable iff (rst) state_ff == bbf_pkg::ST_RUN && scene_en && !main_en
            && !pwm |=> uv_comparator_enable;
    endproperty
    a_uv_scene: assert property (p_uv_scene) else $error("uv comparator off scene");
    property p_uv_idle;
        @(posedge clk) disable iff (rst) state_ff == bbf_pkg::ST_OFF |=> !uv_comparator_enable;
    endproperty
    a_uv_idle: assert property (p_uv_idle) else $error("uv comparator on idle");
    property p_reg_resume;
        @(posedge clk) disable iff (rst) rail_on && !ov_fault |=> regulator_run;
    endproperty
    a_reg_resume: assert property (p_reg_resume) else $error("regulator not resumed");
    property p_gate_resume;
        @(posedge clk) disable iff (rst) rail_on && !ov_fault && !oc_fault |=> switch_gate_allow;
    endproperty
    a_gate_resume: assert property (p_gate_resume) else $error("switch not resumed");
    property p_ss_clear;
        @(posedge clk) disable iff (rst) !ramping |=> ss_cnt_ff == '0;
    endproperty
    a_ss_clear: assert property (p_ss_clear) else $error("soft-start count kept");
endmodule : bbf_boost_ctrl

//--- rtl/bbf_pkg.sv
// package: register map, field layouts and timing for the backlight boost control
package bbf_pkg;
    // register byte offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFF_IRQ_MASK = 4'hC;
    // control fields
    localparam int CTRL_MAIN_POS = 0;
    localparam int CTRL_SCENE_POS = 1;
    localparam int CTRL_FOURTH_POS = 2;
    localparam int CTRL_DUAL_POS = 3;
    localparam int CTRL_PWM_POS = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // interrupt event bit positions
    localparam int EV_UV_POS = 0;
    localparam int EV_OV_POS = 1;
    localparam int EV_OC_POS = 2;
    localparam int EV_SC_POS = 3;
    localparam int EV_OPEN_POS = 4;
    localparam int EV_READY_POS = 5;
    localparam int EV_W = 6;
    localparam logic [5:0] IRQ_MASK_RESET = 6'h00;
    // soft-start timing
    localparam int SOFT_START_US = 4000;
    localparam int CLK_MHZ = 100;
    localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
    // role codes of the fourth string
    localparam logic [1:0] ROLE_OFF = 2'h0;
    localparam logic [1:0] ROLE_CAMERA = 2'h1;
    localparam logic [1:0] ROLE_ZONE_A = 2'h2;
    localparam logic [1:0] ROLE_ZONE_B = 2'h3;

    typedef struct packed {
        logic sink_pwm_mode_enable;
        logic dual_zone_select;
        logic fourth_string_backlight_enable;
        logic scene_string_enable;
        logic main_string_enable;
    } bbf_ctrl_t;

    typedef struct packed {
        logic uv;
        logic ov;
        logic oc;
        logic sc;
        logic [2:0] open_str;
    } bbf_sense_t;

    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_RAMP = 4'h2,
        ST_RUN = 4'h4,
        ST_SHORT = 4'h8
    } bbf_state_t;
endpackage : bbf_pkg

//--- tb/bbf_stage_model.sv
// boost stage, comparator and sink model facing the backlight boost control
`timescale 1ns/1ns
module bbf_stage_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // from the control block
    input wire logic boost_rail_enable,
    // faults the bench asks for
    input wire bbf_pkg::bbf_sense_t inject,
    // comparator pins
    output logic uv_below_pin,
    output logic ov_trip_pin,
    output logic oc_trip_pin,
    output logic fb_short_pin,
    output logic [2:0] main_sink_open_pin,
    output logic boost_output_steady_pin
);
    logic [3:0] ramp_ff;
    logic [3:0] nxt_ramp;
    // output climbs only while the rail is on, collapses at once when it drops
    assign nxt_ramp = boost_rail_enable ? ramp_ff + {3'h0, ramp_ff != 4'hF} : 4'h0;
    assign boost_output_steady_pin = ramp_ff >= 4'h6;
    // below threshold during the ramp as well, not only on request
    assign uv_below_pin = inject.uv | (boost_rail_enable & ~boost_output_steady_pin);
    assign ov_trip_pin = inject.ov;
    assign oc_trip_pin = inject.oc;
    assign fb_short_pin = inject.sc;
    assign main_sink_open_pin = inject.open_str;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ramp_ff <= 4'h0;
        end else begin
            ramp_ff <= nxt_ramp;
        end
    end
endmodule : bbf_stage_model

//--- tb/bbf_boost_ctrl_tb.sv
// self-checking bench for the backlight boost control
`timescale 1ns/1ns
module bbf_boost_ctrl_tb;
    typedef struct packed {
        logic [4:0] ctrl;
        logic rail;
        logic [2:0] act;
        logic [2:0] pwm;
        logic [2:0] zb;
        logic fourth;
        logic [1:0] role;
    } bbf_row_t;
    logic clk, rst, avs_read, avs_write, avs_waitrequest, irq;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic uv_below_pin, ov_trip_pin, oc_trip_pin, fb_short_pin, boost_output_steady_pin;
    logic [2:0] main_sink_open_pin, main_sink_enable, main_sink_pwm_mode, main_sink_zone_b;
    logic [2:0] main_sink_in_loop;
    logic boost_rail_enable, regulator_run, switch_gate_allow, uv_comparator_enable;
    logic boost_fault_flag, fourth_sink_enable, fourth_in_loop;
    logic [1:0] fourth_string_role;
    bbf_pkg::bbf_sense_t inject;
    int err_total, compares;
    bbf_row_t rows [17];

    bbf_boost_ctrl #(.SOFT_START_CYCLES(20)) dut (.clk, .rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
        .uv_below_pin, .ov_trip_pin, .oc_trip_pin, .fb_short_pin, .main_sink_open_pin,
        .boost_output_steady_pin, .boost_rail_enable, .regulator_run, .switch_gate_allow,
        .uv_comparator_enable, .boost_fault_flag, .main_sink_enable, .main_sink_pwm_mode,
        .main_sink_zone_b, .main_sink_in_loop, .fourth_sink_enable, .fourth_string_role,
        .fourth_in_loop, .irq);
    bbf_stage_model stage (.clk, .rst, .boost_rail_enable, .inject, .uv_below_pin,
        .ov_trip_pin, .oc_trip_pin, .fb_short_pin, .main_sink_open_pin,
        .boost_output_steady_pin);

    task complete_run;
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one avalon-mm transfer, held until waitrequest is seen low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        // values seen here are those standing at the edge
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) err_total++;
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    // pins need several cycles to reach the outputs
    task settle;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task hit(input bbf_pkg::bbf_sense_t s);
        @(posedge clk);
        inject <= s;
        settle;
    endtask : hit
    task wait_fault(input logic v);
        int n;
        n = 0;
        while (boost_fault_flag !== v && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (boost_fault_flag !== v) err_total++;
    endtask : wait_fault
    task ctrl(input logic [4:0] c);
        bus(1'b1, bbf_pkg::OFF_CTRL, {27'h0, c});
        settle;
    endtask : ctrl

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        err_total++;
        complete_run;
    end
    initial begin
        rst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        inject = '0;
        err_total = 0;
        compares = 0;
        // ctrl, rail, active, pwm, zone b, fourth on, role; 15 and 16 are the invalid mix
        rows = '{'{5'h00,0,0,0,0,0,0}, '{5'h04,0,0,0,0,0,0}, '{5'h0C,0,0,0,0,0,0},
            '{5'h02,1,0,0,0,1,1}, '{5'h06,1,0,0,0,1,2}, '{5'h0A,1,0,0,0,1,3},
            '{5'h01,1,7,0,0,0,0}, '{5'h05,1,7,0,0,0,0}, '{5'h09,1,7,0,4,0,0},
            '{5'h07,1,7,0,0,1,2}, '{5'h0B,1,7,0,4,1,3}, '{5'h10,0,7,7,0,0,0},
            '{5'h18,0,7,7,4,0,0}, '{5'h12,1,7,7,0,1,1}, '{5'h1A,1,7,7,4,1,3},
            '{5'h11,0,0,0,0,0,0}, '{5'h13,1,0,0,0,1,1}};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(32'({boost_rail_enable, boost_fault_flag, irq, main_sink_enable}), 32'h0);
        bus(1'b0, bbf_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'(bbf_pkg::CTRL_RESET));
        bus(1'b0, bbf_pkg::OFF_IRQ_MASK, 32'h0);
        chk(rd, 32'(bbf_pkg::IRQ_MASK_RESET));
        bus(1'b1, 4'h2, 32'hFF);
        bus(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        foreach (rows[i]) begin
            ctrl(rows[i].ctrl);
            chk(32'({boost_rail_enable, main_sink_enable | main_sink_pwm_mode, main_sink_pwm_mode,
                main_sink_zone_b & (main_sink_enable | main_sink_pwm_mode), fourth_sink_enable,
                fourth_string_role}), 32'(rows[i][12:0]));
        end
        ctrl(5'h00);
        bus(1'b1, bbf_pkg::OFF_IRQ_STAT, 32'h3F);
        ctrl(5'h02);
        chk(32'({boost_fault_flag, uv_comparator_enable}), 32'h3);
        wait_fault(1'b0);
        chk(32'({boost_fault_flag, uv_comparator_enable}), 32'h1);
        hit(7'h40);
        chk(32'(boost_fault_flag), 32'h1);
        hit(7'h00);
        wait_fault(1'b0);
        chk(32'(boost_fault_flag), 32'h0);
        ctrl(5'h00);
        ctrl(5'h01);
        wait_fault(1'b0);
        chk(32'({boost_fault_flag, uv_comparator_enable}), 32'h0);
        // over-voltage and over-current together, then released one by one
        hit(7'h30);
        chk(32'({regulator_run, main_sink_enable, switch_gate_allow, boost_fault_flag}),
            32'h01);
        hit(7'h10);
        chk(32'({regulator_run, main_sink_enable, boost_fault_flag}), 32'h1F);
        hit(7'h00);
        wait_fault(1'b0);
        chk(32'({switch_gate_allow, boost_fault_flag}), 32'h2);
        bus(1'b0, bbf_pkg::OFF_IRQ_STAT, 32'h0);
        chk(rd & 32'h6, 32'h6);
        chk(32'(irq), 32'h0);
        bus(1'b1, bbf_pkg::OFF_IRQ_MASK, 32'h2);
        @(negedge clk);
        chk(32'(irq), 32'h1);
        bus(1'b1, bbf_pkg::OFF_IRQ_STAT, 32'h2);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        hit(7'h02);
        chk(32'({boost_rail_enable, main_sink_in_loop}), 32'hD);
        hit(7'h00);
        // short present from the start: masked in soft-start, then latched
        ctrl(5'h00);
        hit(7'h08);
        ctrl(5'h01);
        chk(32'(boost_rail_enable), 32'h1);
        repeat (30) @(negedge clk);
        chk(32'({boost_rail_enable, boost_fault_flag}), 32'h1);
        hit(7'h00);
        chk(32'({boost_rail_enable, boost_fault_flag}), 32'h1);
        ctrl(5'h00);
        ctrl(5'h01);
        wait_fault(1'b0);
        chk(32'({boost_rail_enable, boost_fault_flag}), 32'h2);
        // reset in mid-run clears everything
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        chk(32'({boost_rail_enable, boost_fault_flag}), 32'h0);
        @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, bbf_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        complete_run;
    end
endmodule : bbf_boost_ctrl_tb
